/* File: logic/pasc_top.sv */
// Summary of operation
// - a severity bit at one sends the matching error as a fatal message
// - a severity bit at zero sends the matching error as a nonfatal message
// - severity register at offset 10Ch, reset value 0006_2031h
// - severity bit 20, read/write, classes unsupported requests
// - bits 19, 18, 17: end-to-end CRC, malformed packet, credit overrun
// - bits 16 to 12: unexpected, abort, timeout, flow credit, poisoned
// - severity bit 4, read/write, classes link layer protocol errors
// - severity bits 31:21, 11:6, 3:1 read only zero
// - severity bits 5 and 0 read only one
// - marked fields survive every reset except the fundamental one
// - fundamental reset asserts while slot or global reset asserts
// - correctable flag register at offset 110h, resets to zero
// - a correctable flag clears when one is written to it (a set in the same cycle wins) or on fundamental reset
// - flag 13 sets on advisory nonfatal error; any reset clears it
// - flag 12 sets on retry timer expiry with unacknowledged packet
// - flag 8 sets on replay counter rollover
// - flag 7 sets on coding error during a link packet
// - flag 6 sets on coding error during a transaction packet
// - flag 0 sets on any coding error at all
// - flag bits 31:14, 11:9, 5:1 read only zero
`timescale 1ns/100ps
`include "pasc_map.svh"

module pasc_top
    import pasc_pkg::*;
(
    input  wire logic          SYS_CLK,
    input  wire logic          SYS_RST,
    input  wire logic          SLOT_RESET_N,
    input  wire logic          GLOBAL_RESET_N,
    input  pasc_addr_type      CFG_ADDR,
    input  pasc_be_type        CFG_BYTE_EN,
    input  wire logic          CFG_WR,
    input  wire logic          CFG_RD,
    input  pasc_word_type      CFG_WDATA,
    output pasc_word_type      CFG_RDATA,
    output logic               CFG_RD_DONE,
    input  pasc_word_type      UNC_ERR_EVENT,
    input  wire logic          ADVISORY_NONFATAL_EVT,
    input  wire logic          RETRY_TIMER_EXPIRED_EVT,
    input  wire logic          REPLAY_ROLLOVER_EVT,
    input  wire logic          CORRUPT_LINK_PACKET_EVT,
    input  wire logic          CORRUPT_TRANSACTION_PACKET_EVT,
    input  wire logic          RX_CODING_ERR_EVT,
    output logic               FATAL_MSG_REQ,
    output logic               NONFATAL_MSG_REQ,
    output logic               FUNDAMENTAL_RESET_N,
    output logic               UNSUPPORTED_REQUEST_CLASS,
    output logic               END_TO_END_CRC_CLASS,
    output logic               MALFORMED_PACKET_CLASS,
    output logic               CREDIT_OVERRUN_CLASS,
    output logic               UNEXPECTED_COMPLETION_CLASS,
    output logic               COMPLETER_ABORT_CLASS,
    output logic               COMPLETION_TIMEOUT_CLASS,
    output logic               FLOW_CREDIT_PROTOCOL_CLASS,
    output logic               POISONED_PACKET_CLASS,
    output logic               LINK_LAYER_PROTOCOL_CLASS,
    output pasc_word_type      CORRECTABLE_FLAGS
);

    localparam pasc_word_type SEV_RW_MASK = `PASC_SEV_RW_MASK;
    localparam pasc_addr_type SEV_ADDR    = `PASC_SEV_OFFSET;
    localparam pasc_addr_type FLAG_ADDR   = `PASC_FLAG_OFFSET;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic pasc_sel_type reg_select(input pasc_addr_type addr);
        pasc_sel_type sel;
        sel = PASC_SEL_NONE;
        if (addr[11:2] == SEV_ADDR[11:2])
        begin
            sel = PASC_SEL_SEVERITY;
        end
        else if (addr[11:2] == FLAG_ADDR[11:2])
        begin
            sel = PASC_SEL_FLAGS;
        end
        return sel;
    endfunction

    function automatic pasc_word_type lane_mask(input pasc_be_type be);
        pasc_word_type m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    // ****************************************************************
    // fundamental reset from the reset pins
    // ****************************************************************
    logic slot_meta_q;
    logic slot_sync_q;
    logic glob_meta_q;
    logic glob_sync_q;
    logic fundamental_reset_n_n_q;

    // no hot reset here: a hot reset must not raise the fundamental
    // reset, or the sticky fields would be lost with it
    always_ff @(posedge SYS_CLK)
    begin
        slot_meta_q <= SLOT_RESET_N;
        slot_sync_q <= slot_meta_q;
    end

    always_ff @(posedge SYS_CLK)
    begin
        glob_meta_q <= GLOBAL_RESET_N;
        glob_sync_q <= glob_meta_q;
    end

    // held low while either synchronised pin is low
    always_ff @(posedge SYS_CLK)
    begin
        fundamental_reset_n_n_q <= slot_sync_q & glob_sync_q;
    end

    assign FUNDAMENTAL_RESET_N = fundamental_reset_n_n_q;

    // ****************************************************************
    // configuration access decode
    // ****************************************************************
    pasc_sel_type  sel;
    pasc_word_type wr_mask;
    logic          sev_wr;
    logic          flag_wr;
    logic          cfg_live;

    // accesses during either reset are dropped
    assign cfg_live = !SYS_RST && fundamental_reset_n_n_q;
    assign sel      = reg_select(CFG_ADDR);
    assign wr_mask  = lane_mask(CFG_BYTE_EN);
    assign sev_wr   = CFG_WR && cfg_live && (sel == PASC_SEL_SEVERITY);
    assign flag_wr  = CFG_WR && cfg_live && (sel == PASC_SEL_FLAGS);

    // ****************************************************************
    // severity register
    // ****************************************************************
    pasc_word_type sev_value;

    pasc_sev_reg u_sev
    (
        .clk     (SYS_CLK),
        .fundamental_reset_n_n  (fundamental_reset_n_n_q),
        .wr_en   (sev_wr),
        .wr_mask (wr_mask),
        .wr_data (CFG_WDATA),
        .value   (sev_value)
    );

    assign UNSUPPORTED_REQUEST_CLASS   = sev_value[`PASC_BIT_UNSUPPORTED];
    assign END_TO_END_CRC_CLASS        = sev_value[`PASC_BIT_E2E_CRC];
    assign MALFORMED_PACKET_CLASS      = sev_value[`PASC_BIT_MALFORMED];
    assign CREDIT_OVERRUN_CLASS        = sev_value[`PASC_BIT_CREDIT];
    assign UNEXPECTED_COMPLETION_CLASS = sev_value[`PASC_BIT_UNEXPECTED];
    assign COMPLETER_ABORT_CLASS       = sev_value[`PASC_BIT_ABORT];
    assign COMPLETION_TIMEOUT_CLASS    = sev_value[`PASC_BIT_TIMEOUT];
    assign FLOW_CREDIT_PROTOCOL_CLASS  = sev_value[`PASC_BIT_FLOW_CREDIT];
    assign POISONED_PACKET_CLASS       = sev_value[`PASC_BIT_POISONED];
    assign LINK_LAYER_PROTOCOL_CLASS   = sev_value[`PASC_BIT_LINK_PROTO];

    // ****************************************************************
    // error message classification
    // ****************************************************************
    pasc_word_type unc_valid;

    assign unc_valid = UNC_ERR_EVENT & SEV_RW_MASK;

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST || !fundamental_reset_n_n_q)
        begin
            FATAL_MSG_REQ <= 1'b0;
        end
        else
        begin
            FATAL_MSG_REQ <= |(unc_valid & sev_value);
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST || !fundamental_reset_n_n_q)
        begin
            NONFATAL_MSG_REQ <= 1'b0;
        end
        else
        begin
            NONFATAL_MSG_REQ <= |(unc_valid & ~sev_value);
        end
    end

    // ****************************************************************
    // correctable flag events and clears
    // ****************************************************************
    pasc_word_type flag_set;
    pasc_word_type flag_clr;
    pasc_word_type flag_value;
    logic          any_coding_err;

    assign any_coding_err = RX_CODING_ERR_EVT
                          | CORRUPT_LINK_PACKET_EVT
                          | CORRUPT_TRANSACTION_PACKET_EVT;

    always_comb
    begin
        flag_set                            = 32'h0000_0000;
        flag_set[`PASC_BIT_ADVISORY]        = ADVISORY_NONFATAL_EVT;
        flag_set[`PASC_BIT_RETRY_TIMER]     = RETRY_TIMER_EXPIRED_EVT;
        flag_set[`PASC_BIT_REPLAY_ROLL]     = REPLAY_ROLLOVER_EVT;
        flag_set[`PASC_BIT_CORRUPT_LINK]    = CORRUPT_LINK_PACKET_EVT;
        flag_set[`PASC_BIT_CORRUPT_TRANS]   = CORRUPT_TRANSACTION_PACKET_EVT;
        flag_set[`PASC_BIT_RX_CODING]       = any_coding_err;
    end

    // write-one-to-clear within enabled byte lanes
    assign flag_clr = flag_wr ? (CFG_WDATA & wr_mask) : 32'h0000_0000;

    pasc_flag_reg u_flags
    (
        .clk     (SYS_CLK),
        .rst     (SYS_RST),
        .fundamental_reset_n_n  (fundamental_reset_n_n_q),
        .set_vec (flag_set),
        .clr_vec (flag_clr),
        .value   (flag_value)
    );

    assign CORRECTABLE_FLAGS = flag_value;

    // ****************************************************************
    // read path, one cycle, no side effects
    // ****************************************************************
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST || !fundamental_reset_n_n_q)
        begin
            CFG_RD_DONE <= 1'b0;
        end
        else
        begin
            CFG_RD_DONE <= CFG_RD;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST || !fundamental_reset_n_n_q)
        begin
            CFG_RDATA <= 32'h0000_0000;
        end
        else if (CFG_RD)
        begin
            unique case (sel)
                PASC_SEL_SEVERITY : CFG_RDATA <= sev_value;
                PASC_SEL_FLAGS    : CFG_RDATA <= flag_value;
                PASC_SEL_NONE     : CFG_RDATA <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: logic/pasc_map.svh */
`ifndef PASC_MAP_SVH
`define PASC_MAP_SVH

// ********************************************************************
// register offsets (extended configuration space, byte addresses)
// ********************************************************************
`define PASC_SEV_OFFSET        12'h10C
`define PASC_FLAG_OFFSET       12'h110

// ********************************************************************
// severity register layout
// ********************************************************************
`define PASC_SEV_RESET         32'h0006_2011
`define PASC_SEV_RW_MASK       32'h001F_F010
`define PASC_SEV_ONES_MASK     32'h0000_0021
`define PASC_BIT_UNSUPPORTED   20
`define PASC_BIT_E2E_CRC       19
`define PASC_BIT_MALFORMED     18
`define PASC_BIT_CREDIT        17
`define PASC_BIT_UNEXPECTED    16
`define PASC_BIT_ABORT         15
`define PASC_BIT_TIMEOUT       14
`define PASC_BIT_FLOW_CREDIT   13
`define PASC_BIT_POISONED      12
`define PASC_BIT_LINK_PROTO    4

// ********************************************************************
// correctable flag register layout
// ********************************************************************
`define PASC_FLAG_RESET        32'h0000_0000
`define PASC_FLAG_USED_MASK    32'h0000_31C1
`define PASC_FLAG_STICKY_MASK  32'h0000_11C1
`define PASC_BIT_ADVISORY      13
`define PASC_BIT_RETRY_TIMER   12
`define PASC_BIT_REPLAY_ROLL   8
`define PASC_BIT_CORRUPT_LINK  7
`define PASC_BIT_CORRUPT_TRANS 6
`define PASC_BIT_RX_CODING     0

`endif

/* File: logic/pasc_pkg.sv */
package pasc_pkg;

    typedef logic [31:0] pasc_word_type;
    typedef logic [11:0] pasc_addr_type;
    typedef logic [3:0]  pasc_be_type;

    typedef enum logic [1:0] {
        PASC_SEL_NONE,
        PASC_SEL_SEVERITY,
        PASC_SEL_FLAGS
    } pasc_sel_type;

endpackage

/* File: logic/pasc_sev_reg.sv */
`timescale 1ns/100ps
`include "pasc_map.svh"

module pasc_sev_reg
    import pasc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          fundamental_reset_n_n,
    input  wire logic          wr_en,
    input  pasc_word_type      wr_mask,
    input  pasc_word_type      wr_data,
    output pasc_word_type      value
);

    localparam pasc_word_type RW_MASK   = `PASC_SEV_RW_MASK;
    localparam pasc_word_type ONES_MASK = `PASC_SEV_ONES_MASK;
    localparam pasc_word_type RESET_VAL = `PASC_SEV_RESET;

    pasc_word_type sev_q;

    // ****************************************************************
    // storage: only the fundamental reset returns defaults
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!fundamental_reset_n_n)
        begin
            sev_q <= RESET_VAL & RW_MASK;
        end
        else if (wr_en)
        begin
            sev_q <= (sev_q & ~(wr_mask & RW_MASK))
                   | (wr_data & wr_mask & RW_MASK);
        end
    end

    // reserved bits: zeros except the fixed ones
    assign value = (sev_q & RW_MASK) | ONES_MASK;

endmodule

/* File: logic/pasc_flag_reg.sv */
`timescale 1ns/100ps
`include "pasc_map.svh"

module pasc_flag_reg
    import pasc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          fundamental_reset_n_n,
    input  pasc_word_type      set_vec,
    input  pasc_word_type      clr_vec,
    output pasc_word_type      value
);

    localparam pasc_word_type USED_MASK   = `PASC_FLAG_USED_MASK;
    localparam pasc_word_type STICKY_MASK = `PASC_FLAG_STICKY_MASK;
    localparam pasc_word_type RESET_VAL   = `PASC_FLAG_RESET;

    // ****************************************************************
    // one flag per implemented bit
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_bit
            if (USED_MASK[i])
            begin : g_used
                logic flag_q;
                always_ff @(posedge clk)
                begin
                    if (!fundamental_reset_n_n)
                    begin
                        flag_q <= RESET_VAL[i];
                    end
                    else if (rst && !STICKY_MASK[i])
                    begin
                        flag_q <= RESET_VAL[i];
                    end
                    else if (set_vec[i])
                    begin
                        flag_q <= 1'b1;
                    end
                    else if (clr_vec[i])
                    begin
                        flag_q <= 1'b0;
                    end
                end
                assign value[i] = flag_q;
            end
            else
            begin : g_rsvd
                assign value[i] = 1'b0;
            end
        end
    endgenerate

endmodule

/* File: sim/pasc_properties.sv */
`timescale 1ns/100ps
`include "pasc_map.svh"

module pasc_properties
    import pasc_pkg::*;
(
    input wire logic    SYS_CLK,
    input wire logic    SYS_RST,
    input wire logic    SLOT_RESET_N,
    input wire logic    GLOBAL_RESET_N,
    input pasc_addr_type CFG_ADDR,
    input pasc_be_type  CFG_BYTE_EN,
    input wire logic    CFG_WR,
    input wire logic    CFG_RD,
    input pasc_word_type CFG_WDATA,
    input pasc_word_type CFG_RDATA,
    input pasc_word_type UNC_ERR_EVENT,
    input wire logic    ADVISORY_NONFATAL_EVT,
    input wire logic    RETRY_TIMER_EXPIRED_EVT,
    input wire logic    REPLAY_ROLLOVER_EVT,
    input wire logic    CORRUPT_LINK_PACKET_EVT,
    input wire logic    CORRUPT_TRANSACTION_PACKET_EVT,
    input wire logic    RX_CODING_ERR_EVT,
    input wire logic    FATAL_MSG_REQ,
    input wire logic    NONFATAL_MSG_REQ,
    input wire logic    FUNDAMENTAL_RESET_N,
    input wire logic    UNSUPPORTED_REQUEST_CLASS,
    input wire logic    END_TO_END_CRC_CLASS,
    input wire logic    MALFORMED_PACKET_CLASS,
    input wire logic    CREDIT_OVERRUN_CLASS,
    input wire logic    UNEXPECTED_COMPLETION_CLASS,
    input wire logic    COMPLETER_ABORT_CLASS,
    input wire logic    COMPLETION_TIMEOUT_CLASS,
    input wire logic    FLOW_CREDIT_PROTOCOL_CLASS,
    input wire logic    POISONED_PACKET_CLASS,
    input wire logic    LINK_LAYER_PROTOCOL_CLASS,
    input pasc_word_type CORRECTABLE_FLAGS
);
    pasc_word_type sev_v, set_v, clr_v, lane_v;
    logic          sev_rd, fat_hit, non_hit;

    assign sev_v = {11'h000, UNSUPPORTED_REQUEST_CLASS, END_TO_END_CRC_CLASS,
        MALFORMED_PACKET_CLASS, CREDIT_OVERRUN_CLASS, UNEXPECTED_COMPLETION_CLASS,
        COMPLETER_ABORT_CLASS, COMPLETION_TIMEOUT_CLASS, FLOW_CREDIT_PROTOCOL_CLASS,
        POISONED_PACKET_CLASS, 7'h00, LINK_LAYER_PROTOCOL_CLASS, 4'h0};
    assign set_v = {18'h0_0000, ADVISORY_NONFATAL_EVT, RETRY_TIMER_EXPIRED_EVT, 3'h0,
        REPLAY_ROLLOVER_EVT, CORRUPT_LINK_PACKET_EVT, CORRUPT_TRANSACTION_PACKET_EVT,
        5'h00, CORRUPT_LINK_PACKET_EVT | CORRUPT_TRANSACTION_PACKET_EVT | RX_CODING_ERR_EVT};
    assign lane_v = {{8{CFG_BYTE_EN[3]}}, {8{CFG_BYTE_EN[2]}},
        {8{CFG_BYTE_EN[1]}}, {8{CFG_BYTE_EN[0]}}};
    assign clr_v = (CFG_WR && CFG_ADDR[11:2] == 10'h044) ? (CFG_WDATA & lane_v) : '0;
    assign sev_rd = CFG_RD && CFG_ADDR[11:2] == 10'h043;
    assign fat_hit = |(UNC_ERR_EVENT & sev_v);
    assign non_hit = |(UNC_ERR_EVENT & ~sev_v & `PASC_SEV_RW_MASK);

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST || !FUNDAMENTAL_RESET_N);

    property p_sev_zero;
        sev_rd |=> (CFG_RDATA & 32'hFFE0_0FCE) == 32'h0000_0000;
    endproperty
    a_sev_zero: assert property (p_sev_zero) else $error("sev reserved bit set");
    property p_sev_ones;
        sev_rd |=> CFG_RDATA[5] && CFG_RDATA[0];
    endproperty
    a_sev_ones: assert property (p_sev_ones) else $error("sev fixed one bit clear");
    property p_sev_mirror;
        sev_rd && !CFG_WR |=> (CFG_RDATA & `PASC_SEV_RW_MASK) == sev_v;
    endproperty
    a_sev_mirror: assert property (p_sev_mirror) else $error("sev read vs class");
    property p_fatal;
        !CFG_WR |=> FATAL_MSG_REQ == $past(fat_hit);
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal message wrong");
    property p_nonfatal;
        !CFG_WR |=> NONFATAL_MSG_REQ == $past(non_hit);
    endproperty
    a_nonfatal: assert property (p_nonfatal) else $error("nonfatal message wrong");
    property p_flag_rsvd;
        (CORRECTABLE_FLAGS & 32'hFFFF_CE3E) == 32'h0000_0000;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag reserved set");
    property p_flag_keep;
        1'b1 |=> ($past(CORRECTABLE_FLAGS) & ~$past(clr_v) & ~CORRECTABLE_FLAGS) == '0;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
    property p_flag_clear;
        (|clr_v) && set_v == '0 |=> (CORRECTABLE_FLAGS & $past(clr_v)) == '0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_flag_set;
        (|set_v) |=> (CORRECTABLE_FLAGS & $past(set_v)) == $past(set_v);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_fundamental_reset_n_pin;
        disable iff (SYS_RST) !SLOT_RESET_N || !GLOBAL_RESET_N |-> ##[1:3] !FUNDAMENTAL_RESET_N;
    endproperty
    a_fundamental_reset_n_pin: assert property (p_fundamental_reset_n_pin) else $error("no fundamental reset");
endmodule

bind pasc_top pasc_properties u_props (.*);

/* File: sim/pasc_msg_sink.sv */
`timescale 1ns/100ps

module pasc_msg_sink
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic fatal,
    input  wire logic nonfatal,
    output int        fatal_cnt,
    output int        nonfatal_cnt
);
    // ********************
    // upstream message tally
    // ********************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fatal_cnt <= 0;
            nonfatal_cnt <= 0;
        end
        else
        begin
            fatal_cnt <= fatal_cnt + int'(fatal);
            nonfatal_cnt <= nonfatal_cnt + int'(nonfatal);
        end
    end
endmodule

/* File: sim/test_pasc_top.sv */
`timescale 1ns/100ps

module test_pasc_top
    import pasc_pkg::*;
;
    typedef struct {logic w; pasc_addr_type a; pasc_be_type b; pasc_word_type d, e;} pasc_row_type;
    logic          SYS_CLK, SYS_RST, SLOT_RESET_N, GLOBAL_RESET_N, CFG_WR, CFG_RD;
    pasc_addr_type CFG_ADDR;
    pasc_be_type   CFG_BYTE_EN;
    pasc_word_type CFG_WDATA, CFG_RDATA, UNC_ERR_EVENT, CORRECTABLE_FLAGS;
    logic          CFG_RD_DONE, FATAL_MSG_REQ, NONFATAL_MSG_REQ, FUNDAMENTAL_RESET_N;
    logic          ADVISORY_NONFATAL_EVT, RETRY_TIMER_EXPIRED_EVT, REPLAY_ROLLOVER_EVT;
    logic          CORRUPT_LINK_PACKET_EVT, CORRUPT_TRANSACTION_PACKET_EVT, RX_CODING_ERR_EVT;
    logic          UNSUPPORTED_REQUEST_CLASS, END_TO_END_CRC_CLASS, MALFORMED_PACKET_CLASS;
    logic          CREDIT_OVERRUN_CLASS, UNEXPECTED_COMPLETION_CLASS, COMPLETER_ABORT_CLASS;
    logic          COMPLETION_TIMEOUT_CLASS, FLOW_CREDIT_PROTOCOL_CLASS, POISONED_PACKET_CLASS;
    logic          LINK_LAYER_PROTOCOL_CLASS;
    logic [5:0]    evs;
    int            failures, num_checks, fat_n, non_n;
    int            bits [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
    pasc_word_type fexp [6] = '{32'h0000_0001, 32'h0000_0041, 32'h0000_0081,
                                32'h0000_0100, 32'h0000_1000, 32'h0000_2000};
    pasc_word_type sev_pat = 32'h000A_A010;
    pasc_row_type  rows [7] = '{
        '{1'b0, 12'h10C, 4'hF, 32'h0000_0000, 32'h0006_2031},
        '{1'b1, 12'h10C, 4'hF, 32'hFFFF_FFFF, 32'h001F_F031},
        '{1'b1, 12'h10C, 4'h4, 32'h0000_0000, 32'h0000_F031},
        '{1'b1, 12'h10C, 4'hB, 32'h0000_0000, 32'h0000_0021},
        '{1'b1, 12'h110, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
        '{1'b1, 12'h114, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
        '{1'b0, 12'h10F, 4'h0, 32'h0000_0000, 32'h0000_0021}};

    assign {ADVISORY_NONFATAL_EVT, RETRY_TIMER_EXPIRED_EVT, REPLAY_ROLLOVER_EVT,
            CORRUPT_LINK_PACKET_EVT, CORRUPT_TRANSACTION_PACKET_EVT, RX_CODING_ERR_EVT} = evs;

    pasc_top uut (.*);
    pasc_msg_sink u_sink (.clk(SYS_CLK), .rst(SYS_RST), .fatal(FATAL_MSG_REQ),
        .nonfatal(NONFATAL_MSG_REQ), .fatal_cnt(fat_n), .nonfatal_cnt(non_n));

    initial
    begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    // ********************
    // checks and bus cycles
    // ********************
    task automatic chk_w(input pasc_word_type got, input pasc_word_type exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wr(input pasc_addr_type a, input pasc_be_type b, input pasc_word_type d);
        @(posedge SYS_CLK);
        CFG_WR <= 1'b1;
        CFG_ADDR <= a;
        CFG_BYTE_EN <= b;
        CFG_WDATA <= d;
        @(posedge SYS_CLK);
        CFG_WR <= 1'b0;
    endtask
    task automatic rd(input pasc_addr_type a, input pasc_word_type e);
        @(posedge SYS_CLK);
        CFG_RD <= 1'b1;
        CFG_ADDR <= a;
        @(posedge SYS_CLK);
        CFG_RD <= 1'b0;
        #1;
        chk_b(CFG_RD_DONE, 1'b1);
        chk_w(CFG_RDATA, e);
    endtask
    task automatic pulse(input logic [5:0] v, input pasc_word_type u);
        @(posedge SYS_CLK);
        evs <= v;
        UNC_ERR_EVENT <= u;
        @(posedge SYS_CLK);
        evs <= 6'h00;
        UNC_ERR_EVENT <= '0;
        #1;
    endtask
    task automatic wait_fundamental_reset_n;
        int n;
        n = 0;
        do
        begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        while (FUNDAMENTAL_RESET_N !== 1'b1 && n < 20);
        chk_b(FUNDAMENTAL_RESET_N, 1'b1);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge SYS_CLK);
        failures++;
        $display("mismatch t=%0t watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        {SYS_RST, SLOT_RESET_N, GLOBAL_RESET_N, CFG_WR, CFG_RD} = 5'b10000;
        {CFG_ADDR, CFG_BYTE_EN, CFG_WDATA, UNC_ERR_EVENT, evs} = '0;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        SLOT_RESET_N <= 1'b1;
        GLOBAL_RESET_N <= 1'b1;
        wait_fundamental_reset_n();
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].b, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(12'h10C, 4'hF, sev_pat);
        foreach (bits[i])
        begin
            pulse(6'h00, 32'h0000_0001 << bits[i]);
            chk_b(FATAL_MSG_REQ, sev_pat[bits[i]]);
            chk_b(NONFATAL_MSG_REQ, !sev_pat[bits[i]]);
        end
        pulse(6'h00, 32'h0018_0021);
        chk_b(FATAL_MSG_REQ, 1'b1);
        chk_b(NONFATAL_MSG_REQ, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            pulse(6'(1 << i), '0);
            chk_w(CORRECTABLE_FLAGS, fexp[i]);
            wr(12'h110, 4'hF, fexp[i]);
            rd(12'h110, 32'h0000_0000);
        end
        chk_w(32'(fat_n), 32'h0000_0006);
        chk_w(32'(non_n), 32'h0000_0006);
        pulse(6'h3F, '0);
        wr(12'h110, 4'hF, 32'h0000_0000);
        wr(12'h110, 4'h0, 32'hFFFF_FFFF);
        rd(12'h110, 32'h0000_31C1);
        wr(12'h110, 4'h1, 32'h0000_0101);
        rd(12'h110, 32'h0000_31C0);
        @(posedge SYS_CLK);
        evs <= 6'h08;
        wr(12'h110, 4'hF, 32'h0000_0100);
        evs <= 6'h00;
        rd(12'h110, 32'h0000_31C0);
        @(posedge SYS_CLK);
        SYS_RST <= 1'b1;
        @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        wait_fundamental_reset_n();
        rd(12'h10C, 32'h000A_A031);
        rd(12'h110, 32'h0000_11C0);
        for (int j = 0; j < 2; j++)
        begin
            wr(12'h10C, 4'hF, 32'hFFFF_FFFF);
            pulse(6'h3F, '0);
            @(posedge SYS_CLK);
            SLOT_RESET_N <= (j != 0);
            GLOBAL_RESET_N <= (j == 0);
            repeat (4) @(posedge SYS_CLK);
            #1;
            chk_b(FUNDAMENTAL_RESET_N, 1'b0);
            @(posedge SYS_CLK);
            SLOT_RESET_N <= 1'b1;
            GLOBAL_RESET_N <= 1'b1;
            wait_fundamental_reset_n();
            rd(12'h10C, 32'h0006_2031);
            rd(12'h110, 32'h0000_0000);
        end
        finish_test();
    end
endmodule
